// ---- logic/tcp_consts.vh ----
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TCP_ADDR_RUN_FLAG   8'h88
`define TCP_ADDR_MODE       8'h89
`define TCP_ADDR_LOW_ZERO   8'h8a
`define TCP_ADDR_LOW_ONE    8'h8b
`define TCP_ADDR_HIGH_ZERO  8'h8c
`define TCP_ADDR_HIGH_ONE   8'h8d
`define TCP_ADDR_AUX        8'h8e
`define TCP_ADDR_WAKE_CLK   8'h8f
`define TCP_ADDR_BAUD_RELOAD 8'h9c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCP_RST_BYTE        8'h00
`define TCP_RST_PRE         4'h0

// ----------------------------------------
// Run/flag register fields
// ----------------------------------------
`define TCP_RF_OVF1         7
`define TCP_RF_RUN1         6
`define TCP_RF_OVF0         5
`define TCP_RF_RUN0         4

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define TCP_MD_GATE1        7
`define TCP_MD_SRC1         6
`define TCP_MD_MODE1        5:4
`define TCP_MD_GATE0        3
`define TCP_MD_SRC0         2
`define TCP_MD_MODE0        1:0

// Mode encodings
`define TCP_MODE_13BIT      2'h0
`define TCP_MODE_16BIT      2'h1
`define TCP_MODE_RELOAD     2'h2
`define TCP_MODE_SPLIT      2'h3

// ----------------------------------------
// Auxiliary register fields
// ----------------------------------------
`define TCP_AX_PRESCALE0    7
`define TCP_AX_PRESCALE1    6
`define TCP_AX_SHIFT_RATE   5
`define TCP_AX_BAUD_RUN     4
`define TCP_AX_SER2_DOUBLE  3
`define TCP_AX_BAUD_RATE    2
`define TCP_AX_RAM_DISABLE  1
`define TCP_AX_BAUD_SRC     0

// ----------------------------------------
// Wake and clock-out register fields
// ----------------------------------------
`define TCP_WK_CAPTURE      7
`define TCP_WK_RECEIVE      6
`define TCP_WK_PIN1         5
`define TCP_WK_PIN0         4
`define TCP_WK_LOW_VOLT     3
`define TCP_WK_BAUD_CLK     2
`define TCP_WK_T1_CLK       1
`define TCP_WK_T0_CLK       0

// ----------------------------------------
// Synchronised pin vector positions
// ----------------------------------------
`define TCP_PIN_IRQ0        0
`define TCP_PIN_IRQ1        1
`define TCP_PIN_CNT0        2
`define TCP_PIN_CNT1        3
`define TCP_PIN_CAPTURE     4
`define TCP_PIN_RECEIVE     5
`define TCP_PIN_COMPARE     6
`define TCP_PIN_COUNT       7

// Interrupt-configured input positions
`define TCP_CFG_T0          0
`define TCP_CFG_T1          1
`define TCP_CFG_SERIAL      2
`define TCP_CFG_CAPTURE     3
`define TCP_CFG_LOW_VOLT    4

// ----------------------------------------
// Timing and limits
// ----------------------------------------
`define TCP_PRE_LAST        4'hb
`define TCP_PRE_STEP        4'h1
`define TCP_BYTE_ONE        8'h01
`define TCP_BYTE_MAX        8'hff
`define TCP_STEP13          14'h0001
`define TCP_STEP16          17'h0_0001
`define TCP_STEP8           9'h001
`define TCP_AUX_RAM_TOP     16'h03ff

`endif

// ---- logic/tcp_timer_pair.v ----
// Functional notes
// - Timer 1 gate set: counts only with run bit and irq pin 1 high.
// - Timer 0 gate set: counts only with run bit and irq pin 0 high.
// - Timer 1 source bit: 0 prescaled clock, 1 count pin 1 falls.
// - Timer 0 source bit: 0 prescaled clock, 1 count pin 0 falls.
// - Timer 1 modes: 13-bit, 16-bit, 8-bit reload, stopped.
// - Timer 0 modes: 13-bit, 16-bit, 8-bit reload.
// - Timer 0 split mode: low byte own controls, high byte timer 1 run.
// - Timer 0 prescale bit: 0 divides by 12, 1 undivided.
// - Timer 1 prescale bit: 0 divides by 12, 1 undivided.
// - Shift rate bit: serial mode-0 tick every 12 or every 2 clocks.
// - Baud timer runs on its run bit, every 12 clocks or every clock.
// - Second serial port rate doubles when its bit is set.
// - Aux RAM selected for 0x0000-0x03FF unless disable bit set.
// - Serial 1 baud source: timer 1 overflow or baud timer.
// - Capture-array wake enable lets capture pin activity wake.
// - Receive-pin wake enable lets receive pin activity wake.
// - Count pin wake enables let count pin activity wake.
// - Low-voltage wake enable lets comparator pin wake.
// - Timer clock-out bit drives count pin, toggling each overflow.
// - Baud clock-out bit drives baud pin, toggling each overflow.
// - Mode 0 counts high byte and low five bits; top three held.
// - Wrap from all ones to zero sets the overflow flag.
// - Setting run bit leaves count registers untouched.
// - Count pin sampled each clock; high then low increments.
// - Overflow flag cleared by software or interrupt vectoring.
//
// Local design decision: the strobed register port.
`include "tcp_consts.vh"

module tcp_timer_pair (
    // Clock and reset
    input  wire        CLOCK_I,
    input  wire        SYS_RST_I,
    // Register port
    input  wire [7:0]  ADDR_I,
    input  wire [7:0]  WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [7:0]  RDATA_O,
    // Interrupt vectoring and flags
    input  wire        T0_ACK_I,
    input  wire        T1_ACK_I,
    output reg         OVF0_O,
    output reg         OVF1_O,
    // Gate and count pins
    input  wire        EXT_IRQ_PIN0_I,
    input  wire        EXT_IRQ_PIN1_I,
    input  wire        COUNT_PIN0_I,
    output reg         COUNT_PIN0_O,
    output reg         COUNT_PIN0_OE_O,
    input  wire        COUNT_PIN1_I,
    output reg         COUNT_PIN1_O,
    output reg         COUNT_PIN1_OE_O,
    // Baud timer clock pin
    output reg         BAUD_CLK_O,
    output reg         BAUD_CLK_OE_O,
    // Serial port steering
    output reg         SER1_BAUD_TICK_O,
    output reg         SER_SHIFT_TICK_O,
    output reg         SER2_RATE_DOUBLE_O,
    // External data mapping
    input  wire        XDATA_REQ_I,
    input  wire [15:0] XDATA_ADDR_I,
    output reg         AUX_RAM_SEL_O,
    output reg         EXT_RAM_SEL_O,
    // Power-down wake
    input  wire        POWER_DOWN_I,
    input  wire [4:0]  IRQ_CFG_I,
    input  wire        CAPTURE_MODULE_PIN_I,
    input  wire        RECEIVE_PIN_I,
    input  wire        COMPARATOR_INPUT_PIN_I,
    output reg         WAKE_O
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] timer_run_flag_reg;
    reg [7:0] timer_mode_config;
    reg [7:0] auxiliary_config;
    reg [7:0] wake_and_clock_out_ctl;
    reg [7:0] count_low_zero;
    reg [7:0] count_high_zero;
    reg [7:0] count_low_one;
    reg [7:0] count_high_one;
    reg [7:0] baud_reload;
    reg [7:0] baud_count;
    reg [3:0] pre_count;
    reg       half_tick;
    reg [`TCP_PIN_COUNT-1:0] pin_meta;
    reg [`TCP_PIN_COUNT-1:0] pin_sync;
    reg [`TCP_PIN_COUNT-1:0] pin_prev;

    // ----------------------------------------
    // One count step for a mode
    // ----------------------------------------
    // Returns {overflow, high byte, low byte}
    function [16:0] tcp_step;
        input [1:0] md;
        input [7:0] tl;
        input [7:0] th;
        reg   [13:0] s13;
        reg   [16:0] s16;
        reg   [8:0]  s8;
        begin
            s13 = {1'b0, th, tl[4:0]} + `TCP_STEP13;
            s16 = {1'b0, th, tl} + `TCP_STEP16;
            s8  = {1'b0, tl} + `TCP_STEP8;
            // Mode 0: top three low bits held, bit 4 carries to high
            case (md)
                `TCP_MODE_13BIT:  tcp_step = {s13[13], s13[12:5], tl[7:5],
                                              s13[4:0]};
                `TCP_MODE_16BIT:  tcp_step = s16;
                `TCP_MODE_RELOAD: tcp_step = {s8[8], th, s8[8] ? th : s8[7:0]};
                default:          tcp_step = {s8[8], th, s8[7:0]};
            endcase
        end
    endfunction

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    wire [1:0] mode0 = timer_mode_config[`TCP_MD_MODE0];
    wire [1:0] mode1 = timer_mode_config[`TCP_MD_MODE1];
    wire       run0  = timer_run_flag_reg[`TCP_RF_RUN0];
    wire       run1  = timer_run_flag_reg[`TCP_RF_RUN1];
    wire       split = (mode0 == `TCP_MODE_SPLIT);
    wire       wr_rf = WR_I && (ADDR_I == `TCP_ADDR_RUN_FLAG);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two flops before use; third stage only for edge finding
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            pin_meta <= {`TCP_PIN_COUNT{1'b0}};
            pin_sync <= {`TCP_PIN_COUNT{1'b0}};
            pin_prev <= {`TCP_PIN_COUNT{1'b0}};
        end else begin
            pin_meta <= {COMPARATOR_INPUT_PIN_I, RECEIVE_PIN_I,
                         CAPTURE_MODULE_PIN_I, COUNT_PIN1_I, COUNT_PIN0_I,
                         EXT_IRQ_PIN1_I, EXT_IRQ_PIN0_I};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end
    wire [`TCP_PIN_COUNT-1:0] pin_act  = pin_sync ^ pin_prev;
    wire                      fall0    = pin_prev[`TCP_PIN_CNT0] &
                                         ~pin_sync[`TCP_PIN_CNT0];
    wire                      fall1    = pin_prev[`TCP_PIN_CNT1] &
                                         ~pin_sync[`TCP_PIN_CNT1];

    // ----------------------------------------
    // Shared divide-by-12 prescaler
    // ----------------------------------------
    // One free counter serves every x12 user, so ticks stay aligned
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            pre_count <= `TCP_RST_PRE;
            half_tick <= 1'b0;
        end else begin
            pre_count <= (pre_count == `TCP_PRE_LAST) ? `TCP_RST_PRE :
                         pre_count + `TCP_PRE_STEP;
            half_tick <= ~half_tick;
        end
    end
    wire tick12 = (pre_count == `TCP_PRE_LAST);
    wire clk0   = auxiliary_config[`TCP_AX_PRESCALE0] | tick12;
    wire clk1   = auxiliary_config[`TCP_AX_PRESCALE1] | tick12;

    // ----------------------------------------
    // Count enables
    // ----------------------------------------
    wire gate_ok0 = ~timer_mode_config[`TCP_MD_GATE0] |
                    pin_sync[`TCP_PIN_IRQ0];
    wire gate_ok1 = ~timer_mode_config[`TCP_MD_GATE1] |
                    pin_sync[`TCP_PIN_IRQ1];
    wire src0     = timer_mode_config[`TCP_MD_SRC0] ? fall0 : clk0;
    wire src1     = timer_mode_config[`TCP_MD_SRC1] ? fall1 : clk1;
    wire inc0     = run0 & gate_ok0 & src0;
    wire inc1     = run1 & gate_ok1 & src1 &
                    (mode1 != `TCP_MODE_SPLIT);
    // High byte of timer 0 in split mode: timer only, timer 1 run bit
    wire inc_hi0  = split & run1 & clk1;
    wire [16:0] step0 = tcp_step(mode0, count_low_zero, count_high_zero);
    wire [16:0] step1 = tcp_step(mode1, count_low_one, count_high_one);
    wire ovf0    = inc0 & step0[16];
    wire ovf1    = inc1 & step1[16];
    wire ovf_hi0 = inc_hi0 & (count_high_zero == `TCP_BYTE_MAX);
    // In split mode the high byte of timer 0 owns the timer 1 flag
    wire set_f1  = split ? ovf_hi0 : ovf1;

    // ----------------------------------------
    // Timer 0 count registers
    // ----------------------------------------
    // A software write in the same cycle as a step wins
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            count_low_zero  <= `TCP_RST_BYTE;
            count_high_zero <= `TCP_RST_BYTE;
        end else begin
            if (inc0) begin
                count_low_zero <= step0[7:0];
                if (!split)
                    count_high_zero <= step0[15:8];
            end
            if (inc_hi0)
                count_high_zero <= count_high_zero + `TCP_BYTE_ONE;
            if (WR_I && ADDR_I == `TCP_ADDR_LOW_ZERO)
                count_low_zero <= WDATA_I;
            if (WR_I && ADDR_I == `TCP_ADDR_HIGH_ZERO)
                count_high_zero <= WDATA_I;
        end
    end

    // ----------------------------------------
    // Timer 1 count registers
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            count_low_one  <= `TCP_RST_BYTE;
            count_high_one <= `TCP_RST_BYTE;
        end else begin
            if (inc1) begin
                count_low_one  <= step1[7:0];
                count_high_one <= step1[15:8];
            end
            if (WR_I && ADDR_I == `TCP_ADDR_LOW_ONE)
                count_low_one <= WDATA_I;
            if (WR_I && ADDR_I == `TCP_ADDR_HIGH_ONE)
                count_high_one <= WDATA_I;
        end
    end

    // ----------------------------------------
    // Run bits and overflow flags
    // ----------------------------------------
    // Hardware set beats software clear and vector clear
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            timer_run_flag_reg <= `TCP_RST_BYTE;
        end else begin
            if (wr_rf)
                timer_run_flag_reg <= WDATA_I; // Counts untouched
            timer_run_flag_reg[`TCP_RF_OVF0] <= ovf0 |
                (wr_rf ? WDATA_I[`TCP_RF_OVF0] :
                 timer_run_flag_reg[`TCP_RF_OVF0] & ~T0_ACK_I);
            timer_run_flag_reg[`TCP_RF_OVF1] <= set_f1 |
                (wr_rf ? WDATA_I[`TCP_RF_OVF1] :
                 timer_run_flag_reg[`TCP_RF_OVF1] & ~T1_ACK_I);
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            timer_mode_config      <= `TCP_RST_BYTE;
            auxiliary_config       <= `TCP_RST_BYTE;
            wake_and_clock_out_ctl <= `TCP_RST_BYTE;
            baud_reload            <= `TCP_RST_BYTE;
        end else if (WR_I) begin
            case (ADDR_I)
                `TCP_ADDR_MODE:        timer_mode_config      <= WDATA_I;
                `TCP_ADDR_AUX:         auxiliary_config       <= WDATA_I;
                `TCP_ADDR_WAKE_CLK:    wake_and_clock_out_ctl <= WDATA_I;
                `TCP_ADDR_BAUD_RELOAD: baud_reload            <= WDATA_I;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Dedicated baud timer
    // ----------------------------------------
    wire baud_inc = auxiliary_config[`TCP_AX_BAUD_RUN] &
                    (auxiliary_config[`TCP_AX_BAUD_RATE] | tick12);
    wire baud_ovf = baud_inc & (baud_count == `TCP_BYTE_MAX);
    // Auto-reload keeps the rate set by the reload byte
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            baud_count <= `TCP_RST_BYTE;
        end else if (baud_ovf) begin
            baud_count <= baud_reload;
        end else if (baud_inc) begin
            baud_count <= baud_count + `TCP_BYTE_ONE;
        end
    end

    // ----------------------------------------
    // Clock-out pins
    // ----------------------------------------
    // Latch toggles on every overflow, giving half the overflow rate
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            COUNT_PIN0_O    <= 1'b0;
            COUNT_PIN0_OE_O <= 1'b0;
            COUNT_PIN1_O    <= 1'b0;
            COUNT_PIN1_OE_O <= 1'b0;
            BAUD_CLK_O      <= 1'b0;
            BAUD_CLK_OE_O   <= 1'b0;
        end else begin
            COUNT_PIN0_OE_O <= wake_and_clock_out_ctl[`TCP_WK_T0_CLK];
            COUNT_PIN1_OE_O <= wake_and_clock_out_ctl[`TCP_WK_T1_CLK];
            BAUD_CLK_OE_O   <= wake_and_clock_out_ctl[`TCP_WK_BAUD_CLK];
            if (ovf0)
                COUNT_PIN0_O <= ~COUNT_PIN0_O;
            if (ovf1)
                COUNT_PIN1_O <= ~COUNT_PIN1_O;
            if (baud_ovf)
                BAUD_CLK_O <= ~BAUD_CLK_O;
        end
    end

    // ----------------------------------------
    // Serial steering and RAM mapping
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            SER1_BAUD_TICK_O   <= 1'b0;
            SER_SHIFT_TICK_O   <= 1'b0;
            SER2_RATE_DOUBLE_O <= 1'b0;
            AUX_RAM_SEL_O      <= 1'b0;
            EXT_RAM_SEL_O      <= 1'b0;
        end else begin
            SER1_BAUD_TICK_O <= auxiliary_config[`TCP_AX_BAUD_SRC] ?
                                baud_ovf : ovf1;
            SER_SHIFT_TICK_O <= auxiliary_config[`TCP_AX_SHIFT_RATE] ?
                                half_tick : tick12;
            SER2_RATE_DOUBLE_O <= auxiliary_config[`TCP_AX_SER2_DOUBLE];
            AUX_RAM_SEL_O <= XDATA_REQ_I &
                             ~auxiliary_config[`TCP_AX_RAM_DISABLE] &
                             (XDATA_ADDR_I <= `TCP_AUX_RAM_TOP);
            EXT_RAM_SEL_O <= XDATA_REQ_I &
                             (auxiliary_config[`TCP_AX_RAM_DISABLE] |
                              (XDATA_ADDR_I > `TCP_AUX_RAM_TOP));
        end
    end

    // ----------------------------------------
    // Power-down wake
    // ----------------------------------------
    wire wk_cap = wake_and_clock_out_ctl[`TCP_WK_CAPTURE] &
                  IRQ_CFG_I[`TCP_CFG_CAPTURE] &
                  pin_act[`TCP_PIN_CAPTURE];
    wire wk_rx  = wake_and_clock_out_ctl[`TCP_WK_RECEIVE] &
                  IRQ_CFG_I[`TCP_CFG_SERIAL] &
                  pin_act[`TCP_PIN_RECEIVE];
    wire wk_t0  = wake_and_clock_out_ctl[`TCP_WK_PIN0] &
                  IRQ_CFG_I[`TCP_CFG_T0] & pin_act[`TCP_PIN_CNT0];
    wire wk_t1  = wake_and_clock_out_ctl[`TCP_WK_PIN1] &
                  IRQ_CFG_I[`TCP_CFG_T1] & pin_act[`TCP_PIN_CNT1];
    wire wk_lv  = wake_and_clock_out_ctl[`TCP_WK_LOW_VOLT] &
                  IRQ_CFG_I[`TCP_CFG_LOW_VOLT] &
                  pin_act[`TCP_PIN_COMPARE];
    // Pulse only while powered down; activity otherwise is ignored
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            WAKE_O <= 1'b0;
        end else begin
            WAKE_O <= POWER_DOWN_I & (wk_cap | wk_rx | wk_t0 | wk_t1 | wk_lv);
        end
    end

    // ----------------------------------------
    // Flag outputs and read port
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            OVF0_O  <= 1'b0;
            OVF1_O  <= 1'b0;
            RDATA_O <= `TCP_RST_BYTE;
        end else begin
            OVF0_O <= timer_run_flag_reg[`TCP_RF_OVF0];
            OVF1_O <= timer_run_flag_reg[`TCP_RF_OVF1];
            if (RD_I) begin
                case (ADDR_I)
                    `TCP_ADDR_RUN_FLAG:    RDATA_O <= timer_run_flag_reg;
                    `TCP_ADDR_MODE:        RDATA_O <= timer_mode_config;
                    `TCP_ADDR_LOW_ZERO:    RDATA_O <= count_low_zero;
                    `TCP_ADDR_LOW_ONE:     RDATA_O <= count_low_one;
                    `TCP_ADDR_HIGH_ZERO:   RDATA_O <= count_high_zero;
                    `TCP_ADDR_HIGH_ONE:    RDATA_O <= count_high_one;
                    `TCP_ADDR_AUX:         RDATA_O <= auxiliary_config;
                    `TCP_ADDR_WAKE_CLK:    RDATA_O <= wake_and_clock_out_ctl;
                    `TCP_ADDR_BAUD_RELOAD: RDATA_O <= baud_reload;
                    default:               RDATA_O <= `TCP_RST_BYTE;
                endcase
            end else begin
                RDATA_O <= `TCP_RST_BYTE; // Data stand one cycle only
            end
        end
    end

endmodule

// ---- verif/tcp_pin_model.sv ----
// ----------------------------------------
// Far-side pin driver
// ----------------------------------------
module tcp_pin_model (
    // Clock
    input  wire  clk_i,
    // Pin levels
    output logic gate0_o,
    output logic gate1_o,
    output logic cnt0_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels: gates open, count line high
    initial begin
        gate0_o = 1'b1;
        gate1_o = 1'b1;
        cnt0_o  = 1'b1;
    end
    // Four clocks each level, well above the sampling need
    task automatic pulses(input int n);
        repeat (n) begin
            cnt0_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            cnt0_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule

// ---- verif/tcp_timer_pair_properties.sv ----
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module tcp_timer_pair_properties (
    // Clock and reset
    input wire        CLOCK_I,
    input wire        SYS_RST_I,
    // Watched ports
    input wire        WR_I,
    input wire [7:0]  ADDR_I,
    input wire        XDATA_REQ_I,
    input wire [15:0] XDATA_ADDR_I,
    input wire        AUX_RAM_SEL_O,
    input wire        EXT_RAM_SEL_O,
    input wire        SER_SHIFT_TICK_O,
    input wire        SER2_RATE_DOUBLE_O,
    input wire        OVF0_O,
    input wire        COUNT_PIN0_O,
    input wire        COUNT_PIN0_OE_O,
    input wire        BAUD_CLK_OE_O,
    input wire        POWER_DOWN_I,
    input wire        WAKE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    // Mapping and steering outputs
    AST_XHI: assert property (
        XDATA_REQ_I && XDATA_ADDR_I > 16'h03ff |=> !AUX_RAM_SEL_O)
        else $error("high address mapped on-chip");
    AST_XONE: assert property (
        XDATA_REQ_I |=> AUX_RAM_SEL_O != EXT_RAM_SEL_O)
        else $error("not exactly one ram target");
    AST_SHIFT: assert property (
        SER_SHIFT_TICK_O |=> !SER_SHIFT_TICK_O)
        else $error("shift tick too long");
    AST_S2: assert property (
        $changed(SER2_RATE_DOUBLE_O) |-> $past(WR_I, 2)
        && $past(ADDR_I, 2) == 8'h8e) else $error("double bit moved");
    // Clock-out pin enables change only by a write two edges back
    AST_OE0: assert property (
        $changed(COUNT_PIN0_OE_O) |-> $past(WR_I, 2)
        && $past(ADDR_I, 2) == 8'h8f) else $error("pin0 enable moved");
    AST_BOE: assert property (
        $changed(BAUD_CLK_OE_O) |-> $past(WR_I, 2)
        && $past(ADDR_I, 2) == 8'h8f) else $error("baud enable moved");
    AST_TOG: assert property (
        $rose(OVF0_O) && COUNT_PIN0_OE_O |->
        $past(COUNT_PIN0_O, 1) != $past(COUNT_PIN0_O, 2))
        else $error("overflow without pin toggle");
    AST_WAKE: assert property (
        !POWER_DOWN_I [*3] |=> !WAKE_O) else $error("wake while awake");
endmodule
bind tcp_timer_pair tcp_timer_pair_properties i_props (.CLOCK_I,
    .SYS_RST_I, .WR_I, .ADDR_I, .XDATA_REQ_I, .XDATA_ADDR_I,
    .AUX_RAM_SEL_O, .EXT_RAM_SEL_O, .SER_SHIFT_TICK_O,
    .SER2_RATE_DOUBLE_O, .OVF0_O, .COUNT_PIN0_O, .COUNT_PIN0_OE_O,
    .BAUD_CLK_OE_O, .POWER_DOWN_I, .WAKE_O);

// ---- verif/tcp_timer_pair_tb.sv ----
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tcp_timer_pair_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, wr_s, rd_s, ack, xreq, pd;
    logic [7:0]  addr, wdata, d, e;
    logic [15:0] xaddr;
    logic [4:0]  cfg;
    wire  [7:0]  rdata;
    wire  [2:0]  fl;
    wire         p0o, p0e, p1o, p1e, g0, g1, m0, aux_sel, ser2, sh;
    int          error_cnt, checked, i, wakes, shifts, s0;
    // Two-way count pins: design wins while it drives
    wire c0 = p0e ? p0o : m0;
    wire c1 = p1e ? p1o : 1'b1;
    tcp_pin_model i_pins (.clk_i(clk), .gate0_o(g0), .gate1_o(g1),
        .cnt0_o(m0));
    tcp_timer_pair i_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .T0_ACK_I(ack), .T1_ACK_I(ack), .OVF0_O(fl[0]), .OVF1_O(fl[1]),
        .EXT_IRQ_PIN0_I(g0), .EXT_IRQ_PIN1_I(g1), .COUNT_PIN0_I(c0),
        .COUNT_PIN0_O(p0o), .COUNT_PIN0_OE_O(p0e), .COUNT_PIN1_I(c1),
        .COUNT_PIN1_O(p1o), .COUNT_PIN1_OE_O(p1e), .BAUD_CLK_O(),
        .BAUD_CLK_OE_O(), .SER1_BAUD_TICK_O(), .SER_SHIFT_TICK_O(sh),
        .SER2_RATE_DOUBLE_O(ser2), .XDATA_REQ_I(xreq),
        .XDATA_ADDR_I(xaddr), .AUX_RAM_SEL_O(aux_sel),
        .EXT_RAM_SEL_O(), .POWER_DOWN_I(pd), .IRQ_CFG_I(cfg),
        .CAPTURE_MODULE_PIN_I(1'b0), .RECEIVE_PIN_I(g1),
        .COMPARATOR_INPUT_PIN_I(1'b0), .WAKE_O(fl[2]));
    // Short pulses tallied mid-cycle, away from the launching edge
    always @(negedge clk) if (fl[2] === 1'b1) wakes++;
    always @(negedge clk) if (sh === 1'b1) shifts++;
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chkr(input logic [7:0] g, input logic [7:0] lo, hi);
        chk(((g >= lo) === 1'b1 && (g <= hi) === 1'b1) ? lo : g, lo);
    endtask
    // Bus cycles: drive after a rising edge, sample at the falling one
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] v;
        rd(a, v);
        chk(v, x);
    endtask
    task automatic waitf(input int k, input int n);
        repeat (n) if (fl[k] !== 1'b1) @(negedge clk);
        chk(fl[k], 1'b1);
        if (fl[k] !== 1'b1) wrap_up();
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Main sequence
    initial begin
        {rst, wr_s, rd_s, ack, xreq, pd} = 6'h20;
        {addr, wdata, xaddr, cfg} = 37'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h89, 8'h00);
        rdc(8'h8f, 8'h00);
        rdc(8'h90, 8'h00);
        wr(8'h8e, 8'h80);
        wr(8'h8f, 8'h05);
        wr(8'h89, 8'h01);
        wr(8'h8c, 8'hff);
        wr(8'h8a, 8'hf0);
        wr(8'h88, 8'h10);
        waitf(0, 40);
        chk(p0o, 1'b1);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(negedge clk);
        chk(fl[0], 1'b0);
        wr(8'h88, 8'h00);
        wr(8'h8f, 8'h00);
        wr(8'h89, 8'h05);
        wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h88, 8'h10);
        i_pins.pulses(5);
        wr(8'h88, 8'h00);
        rdc(8'h8a, 8'h05);
        wr(8'h89, 8'h09);
        wr(8'h8a, 8'h00);
        i_pins.gate0_o <= 1'b0;
        wr(8'h88, 8'h10);
        repeat (20) @(posedge clk);
        rdc(8'h8a, 8'h00);
        i_pins.gate0_o <= 1'b1;
        repeat (20) @(posedge clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, d);
        chkr(d, 8'h0a, 8'h28);
        wr(8'h88, 8'h10);
        repeat (10) @(posedge clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, e);
        chkr(e, d + 8'h05, d + 8'h14);
        wr(8'h8e, 8'h00);
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'h00);
        wr(8'h88, 8'h10);
        repeat (120) @(posedge clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, d);
        chkr(d, 8'h09, 8'h0c);
        wr(8'h8e, 8'h40);
        wr(8'h89, 8'h03);
        wr(8'h8c, 8'hf0);
        wr(8'h88, 8'h40);
        waitf(1, 60);
        wr(8'h89, 8'h30);
        wr(8'h8b, 8'h10);
        wr(8'h88, 8'h40);
        repeat (30) @(posedge clk);
        rdc(8'h8b, 8'h10);
        chk(fl[1], 1'b0);
        wr(8'h8e, 8'h80);
        wr(8'h89, 8'h00);
        wr(8'h8c, 8'hff);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        waitf(0, 40);
        wr(8'h88, 8'h00);
        rd(8'h8a, d);
        chk(d[7:5], 3'h7);
        rdc(8'h8c, 8'h00);
        wr(8'h89, 8'h02);
        wr(8'h8c, 8'ha0);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        waitf(0, 40);
        wr(8'h88, 8'h00);
        rd(8'h8a, d);
        chkr(d, 8'ha0, 8'ha8);
        for (i = 0; i < 4; i++) begin
            wr(8'h8e, {2'h0, i[1], 1'b0, i[1], 1'b0, i[1], 1'b0});
            @(posedge clk);
            xreq  <= 1'b1;
            xaddr <= i[0] ? 16'h0400 : 16'h03ff;
            @(posedge clk);
            xreq  <= 1'b0;
            @(negedge clk);
            chk(aux_sel, !i[1] && !i[0]);
            chk(ser2, i[1]);
            @(posedge clk);
            s0 = shifts;
            repeat (12) @(posedge clk);
            chk(shifts - s0, i[1] ? 6 : 1);
        end
        wr(8'h8f, 8'h10);
        cfg <= 5'h01;
        pd  <= 1'b1;
        i_pins.pulses(1);
        chk(wakes, 2);
        wrap_up();
    end
endmodule
